// [design/pagpio_top.sv]
`timescale 1ns/1ps
`include "pagpio_map.svh"
// Behaviour
// - step-up control bit 0 enables low-pin step-up circuit, 1 disables; resets 0
// - mode bits 0 and 1 route output pins 0/1 to pulse outputs
// - port A read returns latch for output pins, live level for inputs
// - port A data resets to F0
// - direction bit 1 makes pin an output from latch, 0 an input
// - direction and data apply only while pins assigned to general I/O
// - direction register is write-only and reads all ones
// - direction register resets to F0, all pins inputs
// - output-only port data resets to FF
// - nonzero segment select drives port A pins as LCD commons
module pagpio_top (
    // bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // output-only port
    output logic [5:0] output_port_pin,
    output logic stepup_enable,
    output logic stepup_settled,
    input wire logic pulse_out_one,
    input wire logic pulse_out_two,
    // port a pins and lcd commons
    input wire logic [3:0] port_a_in,
    output logic [3:0] port_a_out,
    output logic [3:0] port_a_oe,
    input wire logic [3:0] lcd_common_in
);
    import pagpio_pkg::*;

    // ==========================================
    // state
    pagpio_aphase_t aph_r, aph_nxt;
    logic [5:0] opd_r, opd_nxt;
    logic [7:0] mode_r, mode_nxt;
    logic [3:0] pad_r, pad_nxt;
    logic [3:0] dir_r, dir_nxt;
    logic [3:0] lcd_seg_r, lcd_seg_nxt;
    logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_live_r, pin_live_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    pagpio_su_state_t su_r, su_nxt;
    logic [4:0] su_cnt_r, su_cnt_nxt;
    logic [7:0] wb;
    logic wr_en;
    logic gpio_sel;

    // address match helper, used for both read and write decode
    function automatic logic hit(input logic [17:0] a, input logic [17:0] ref_a);
        hit = (a == ref_a);
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign wb = hwdata[7:0];
    assign wr_en = aph_r.sel && aph_r.write;
    // ==========================================
    // gpio ownership
    assign gpio_sel = (lcd_seg_r == 4'h0);

    // bus phase, register writes and read data
    always_comb begin
        aph_nxt = aph_r;
        opd_nxt = opd_r;
        mode_nxt = mode_r;
        pad_nxt = pad_r;
        dir_nxt = dir_r;
        lcd_seg_nxt = lcd_seg_r;
        rdata_nxt = rdata_r;
        if (hready) begin
            aph_nxt.sel = hsel && htrans[1];
            aph_nxt.addr = haddr[17:0];
            aph_nxt.write = hwrite;
            aph_nxt.size = hsize;
        end
        if (wr_en) begin
            if (hit(aph_r.addr, `PAGPIO_ADDR_PORT_A_DATA)) begin
                pad_nxt = wb[3:0];
            end else if (hit(aph_r.addr, `PAGPIO_ADDR_OUTPUT_PORT_DATA)) begin
                opd_nxt = wb[5:0];
            end else if (hit(aph_r.addr, `PAGPIO_ADDR_OUTPUT_PORT_MODE)) begin
                // upper bits kept at one; bit 2 stored as written
                mode_nxt = `PAGPIO_MODE_UNUSED_MASK | {4'h0, wb[3:0]};
            end else if (hit(aph_r.addr, `PAGPIO_ADDR_PORT_A_DIRECTION)) begin
                dir_nxt = wb[3:0];
            end else if (hit(aph_r.addr, `PAGPIO_ADDR_LCD_PORT_CONTROL)) begin
                lcd_seg_nxt = wb[3:0];
            end
        end
        // read data prepared in the address phase, returned in the data phase;
        // built from the next values so a write still in its data phase is not read back stale
        if (hready) begin
            rdata_nxt = 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite) begin
                if (hit(haddr[17:0], `PAGPIO_ADDR_PORT_A_DATA)) begin
                    // latch or live level; upper ones
                    rdata_nxt = {24'h000000, 4'hF, (dir_nxt & pad_nxt) | (~dir_nxt & pin_live_r)};
                end else if (hit(haddr[17:0], `PAGPIO_ADDR_OUTPUT_PORT_DATA)) begin
                    rdata_nxt = {24'h000000, 2'b11, opd_nxt};
                end else if (hit(haddr[17:0], `PAGPIO_ADDR_OUTPUT_PORT_MODE)) begin
                    rdata_nxt = {24'h000000, mode_nxt};
                end else if (hit(haddr[17:0], `PAGPIO_ADDR_PORT_A_DIRECTION)) begin
                    rdata_nxt = {24'h000000, 8'hFF};
                end else if (hit(haddr[17:0], `PAGPIO_ADDR_LCD_PORT_CONTROL)) begin
                    rdata_nxt = {24'h000000, 4'h0, lcd_seg_nxt};
                end
            end
        end
    end

    // bus and register flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r <= '0;
            opd_r <= 6'h3F;
            mode_r <= `PAGPIO_RST_OUTPUT_PORT_MODE;
            pad_r <= 4'h0;
            dir_r <= 4'h0;
            lcd_seg_r <= 4'h0;
            rdata_r <= 32'h0000_0000;
        end else if (clk_en) begin
            aph_r <= aph_nxt;
            opd_r <= opd_nxt;
            mode_r <= mode_nxt;
            pad_r <= pad_nxt;
            dir_r <= dir_nxt;
            lcd_seg_r <= lcd_seg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================
    // pin synchroniser: change accepted when stages two and three agree
    always_comb begin
        pin_live_nxt = pin_live_r;
        for (int i = 0; i < 4; i++) begin
            if (pin_s2_r[i] == pin_s3_r[i]) begin
                pin_live_nxt[i] = pin_s3_r[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
            pin_live_r <= 4'h0;
        end else if (clk_en) begin
            pin_s1_r <= port_a_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_live_r <= pin_live_nxt;
        end
    end

    // ==========================================
    // step-up settle tracker, a status aid: the hardware does not hold off the pins
    always_comb begin
        su_nxt = su_r;
        su_cnt_nxt = su_cnt_r;
        case (su_r)
            PAGPIO_SU_OFF: begin
                if (!mode_r[`PAGPIO_BIT_STEPUP_DISABLE]) begin
                    su_nxt = PAGPIO_SU_SETTLING;
                    su_cnt_nxt = 5'd0;
                end
            end
            PAGPIO_SU_SETTLING: begin
                if (mode_r[`PAGPIO_BIT_STEPUP_DISABLE]) begin
                    su_nxt = PAGPIO_SU_OFF;
                end else if (su_cnt_r == 5'(`PAGPIO_STEPUP_WAIT_CYCLES - 1)) begin
                    su_nxt = PAGPIO_SU_READY;
                end else begin
                    su_cnt_nxt = su_cnt_r + 5'd1;
                end
            end
            PAGPIO_SU_READY: begin
                if (mode_r[`PAGPIO_BIT_STEPUP_DISABLE]) begin
                    su_nxt = PAGPIO_SU_OFF;
                end
            end
            default: begin
                su_nxt = PAGPIO_SU_OFF;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            su_r <= PAGPIO_SU_OFF;
            su_cnt_r <= 5'd0;
        end else if (clk_en) begin
            su_r <= su_nxt;
            su_cnt_r <= su_cnt_nxt;
        end
    end

    // ==========================================
    // pin drive
    // step-up enable is the inverse of the control bit
    assign stepup_enable = ~mode_r[`PAGPIO_BIT_STEPUP_DISABLE];
    assign stepup_settled = (su_r == PAGPIO_SU_READY);
    // pulse routing on pins 0 and 1
    assign output_port_pin = {opd_r[5:2], mode_r[1] ? pulse_out_two : opd_r[1],
                              mode_r[0] ? pulse_out_one : opd_r[0]};
    assign port_a_out = gpio_sel ? pad_r : lcd_common_in;
    assign port_a_oe = gpio_sel ? dir_r : 4'hF;

    // ==========================================
    // checks
    sequence su_enable_s;
        $fell(mode_r[`PAGPIO_BIT_STEPUP_DISABLE]) && clk_en;
    endsequence

    stepup_pol_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stepup_enable == !mode_r[3]) else $error("step-up enable polarity wrong");
    stepup_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        su_enable_s |-> !stepup_settled) else $error("step-up settled too early");
    pwm_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_r[0] |-> output_port_pin[0] == pulse_out_one) else $error("pulse one not routed");
    read_mix_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans[1] && !hwrite && haddr[17:0] == `PAGPIO_ADDR_PORT_A_DATA && clk_en)
        |=> hrdata[3:0] == (($past(dir_nxt) & $past(pad_nxt)) | (~$past(dir_nxt) & $past(pin_live_r))))
        else $error("port a read mix wrong");
    dir_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        gpio_sel |-> port_a_oe == dir_r && port_a_out == pad_r) else $error("gpio drive wrong");
    dir_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans[1] && !hwrite && haddr[17:0] == `PAGPIO_ADDR_PORT_A_DIRECTION && clk_en)
        |=> hrdata == 32'h0000_00FF) else $error("direction read not ones");
    lcd_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
        lcd_seg_r != 4'h0 |-> port_a_oe == 4'hF && port_a_out == lcd_common_in) else $error("lcd not driving");
    upper_ones_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_r[7:4] == 4'hF) else $error("mode upper bits not one");

    // check helper: cycles of step-up enable, saturating so it cannot wrap back under the limit
    logic [5:0] su_run_r, su_run_nxt;
    always_comb begin
        su_run_nxt = su_run_r;
        if (!stepup_enable) begin
            su_run_nxt = 6'h00;
        end else if (su_run_r != 6'h3F) begin
            su_run_nxt = su_run_r + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            su_run_r <= 6'h00;
        end else if (clk_en) begin
            su_run_r <= su_run_nxt;
        end
    end

    settle_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stepup_settled == (su_run_r >= 6'h1F)) else $error("step-up settle count wrong");
endmodule // pagpio_top

// [shared/pagpio_map.svh]
`ifndef PAGPIO_MAP_SVH
`define PAGPIO_MAP_SVH
// ==========================================
// register byte addresses (index times four)
`define PAGPIO_IDX_PORT_A_DATA 16'hFFDD
`define PAGPIO_IDX_OUTPUT_PORT_DATA 16'hFFDC
`define PAGPIO_IDX_OUTPUT_PORT_MODE 16'hFFEC
`define PAGPIO_IDX_PORT_A_DIRECTION 16'hFFED
`define PAGPIO_IDX_LCD_PORT_CONTROL 16'hFFC0
`define PAGPIO_ADDR_PORT_A_DATA 18'h3FF74
`define PAGPIO_ADDR_OUTPUT_PORT_DATA 18'h3FF70
`define PAGPIO_ADDR_OUTPUT_PORT_MODE 18'h3FFB0
`define PAGPIO_ADDR_PORT_A_DIRECTION 18'h3FFB4
`define PAGPIO_ADDR_LCD_PORT_CONTROL 18'h3FF00
// ==========================================
// reset values and field positions
`define PAGPIO_RST_PORT_A_DATA 8'hF0
`define PAGPIO_RST_PORT_A_DIRECTION 8'hF0
`define PAGPIO_RST_OUTPUT_PORT_DATA 8'hFF
`define PAGPIO_RST_OUTPUT_PORT_MODE 8'hF0
`define PAGPIO_RST_LCD_PORT_CONTROL 8'h00
`define PAGPIO_MODE_UNUSED_MASK 8'hF0
`define PAGPIO_BIT_STEPUP_DISABLE 3
`define PAGPIO_BIT_RESERVED 2
// ==========================================
// step-up settle time
`define PAGPIO_STEPUP_WAIT_CYCLES 30
`endif

// [shared/pagpio_pkg.sv]
package pagpio_pkg;
    // ==========================================
    // bus carrier
    typedef struct packed {
        logic sel;
        logic [17:0] addr;
        logic write;
        logic [2:0] size;
    } pagpio_aphase_t;
    // ==========================================
    // step-up settle tracker states
    typedef enum logic [1:0] {
        PAGPIO_SU_OFF = 2'b00,
        PAGPIO_SU_SETTLING = 2'b01,
        PAGPIO_SU_READY = 2'b11
    } pagpio_su_state_t;
endpackage

// [dv/pagpio_pins.sv]
`timescale 1ns/1ps
// ==========================================
// port a pin loads
module pagpio_pins (
    // pins from the block
    input wire logic [3:0] port_a_out,
    input wire logic [3:0] port_a_oe,
    // level the outside world applies to undriven pins
    input wire logic [3:0] ext_level,
    // level seen back at the block
    output logic [3:0] port_a_in
);
    // pin resolution
    // a driven pin shows the block's value, an undriven one the load's level
    assign port_a_in = (port_a_out & port_a_oe) | (ext_level & ~port_a_oe);
endmodule // pagpio_pins

// [dv/test_pagpio_top.sv]
`timescale 1ns/1ps
`include "pagpio_map.svh"
// ==========================================
// bench top
module test_pagpio_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [5:0] output_port_pin;
    logic stepup_enable;
    logic stepup_settled;
    logic pulse_out_one = 1'b0;
    logic pulse_out_two = 1'b0;
    logic [3:0] port_a_in;
    logic [3:0] port_a_out;
    logic [3:0] port_a_oe;
    logic [3:0] lcd_common_in = 4'h0;
    logic clk_en = 1'b1;
    logic [3:0] ext_level = 4'h9;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    // hsize is tied: only whole-word transfers are made
    pagpio_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .output_port_pin(output_port_pin),
        .stepup_enable(stepup_enable), .stepup_settled(stepup_settled), .pulse_out_one(pulse_out_one),
        .pulse_out_two(pulse_out_two), .port_a_in(port_a_in), .port_a_out(port_a_out),
        .port_a_oe(port_a_oe), .lcd_common_in(lcd_common_in));
    pagpio_pins pins (.port_a_out(port_a_out), .port_a_oe(port_a_oe), .ext_level(ext_level),
        .port_a_in(port_a_in));

    initial begin
        forever #5 hclk = ~hclk;
    end

    // ==========================================
    // bus tasks and checks
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address phase held until hready, then data phase until hready again
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // waits two cycles so that pin outputs have settled
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
        repeat (2) @(negedge hclk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 8'h0, q);
        chk(q, exp);
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    // ==========================================
    // tests
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(negedge hclk);
        chk(output_port_pin, 32'h3F);
        chk(stepup_enable, 32'h1);
        chk(port_a_oe, 32'h0);
        chk(port_a_out, 32'h0);
        rd(`PAGPIO_ADDR_PORT_A_DATA, 32'hF9);
        rd(`PAGPIO_ADDR_PORT_A_DIRECTION, 32'hFF);
        rd(`PAGPIO_ADDR_OUTPUT_PORT_MODE, 32'hF0);
        rd(`PAGPIO_ADDR_OUTPUT_PORT_DATA, 32'hFF);
        rd(32'h100, 32'h0);
        $display("test reset values done");
        // pins 0 and 2 driven low from the latch, 1 and 3 follow the load
        wr(`PAGPIO_ADDR_PORT_A_DATA, 8'h0A);
        wr(`PAGPIO_ADDR_PORT_A_DIRECTION, 8'h05);
        chk(port_a_oe, 32'h5);
        chk(port_a_out & port_a_oe, 32'h0);
        repeat (6) @(negedge hclk);
        rd(`PAGPIO_ADDR_PORT_A_DATA, 32'hF8);
        wr(`PAGPIO_ADDR_PORT_A_DIRECTION, 8'hFF);
        rd(`PAGPIO_ADDR_PORT_A_DATA, 32'hFA);
        rd(`PAGPIO_ADDR_PORT_A_DIRECTION, 32'hFF);
        wr(`PAGPIO_ADDR_PORT_A_DATA, 8'h05);
        rd(`PAGPIO_ADDR_PORT_A_DATA, 32'hF5);
        $display("test port a done");
        lcd_common_in <= 4'h6;
        wr(`PAGPIO_ADDR_LCD_PORT_CONTROL, 8'h01);
        chk(port_a_out, 32'h6);
        chk(port_a_oe, 32'hF);
        wr(`PAGPIO_ADDR_LCD_PORT_CONTROL, 8'h00);
        chk(port_a_out, 32'h5);
        $display("test lcd takeover done");
        pulse_out_one <= 1'b1;
        // bit 2 written zero, output data still all ones when bit 3 moves
        wr(`PAGPIO_ADDR_OUTPUT_PORT_MODE, 8'hFB);
        chk(stepup_enable, 32'h0);
        chk(output_port_pin, 32'h3D);
        rd(`PAGPIO_ADDR_OUTPUT_PORT_MODE, 32'hFB);
        pulse_out_one <= 1'b0;
        pulse_out_two <= 1'b1;
        @(negedge hclk);
        chk(output_port_pin, 32'h3E);
        wr(`PAGPIO_ADDR_OUTPUT_PORT_MODE, 8'h03);
        chk(stepup_enable, 32'h1);
        chk(stepup_settled, 32'h0);
        repeat (40) @(negedge hclk);
        chk(stepup_settled, 32'h1);
        // freeze: the settle count must not advance while clk_en is low
        wr(`PAGPIO_ADDR_OUTPUT_PORT_MODE, 8'h0B);
        chk(stepup_settled, 32'h0);
        wr(`PAGPIO_ADDR_OUTPUT_PORT_MODE, 8'h03);
        @(posedge hclk);
        clk_en <= 1'b0;
        repeat (40) @(negedge hclk);
        chk(stepup_settled, 32'h0);
        @(posedge hclk);
        clk_en <= 1'b1;
        repeat (40) @(negedge hclk);
        chk(stepup_settled, 32'h1);
        wr(`PAGPIO_ADDR_OUTPUT_PORT_MODE, 8'h00);
        // low data only after the settle time has run out
        wr(`PAGPIO_ADDR_OUTPUT_PORT_DATA, 8'h2A);
        chk(output_port_pin, 32'h2A);
        $display("test output port done");
        close_out();
    end
endmodule // test_pagpio_top
